//--- tb/lcd_frame_geometry_and_sleep_tb.sv
// testbench for the geometry, scan timing and standby block
`timescale 1ns/1ns
module lcd_frame_geometry_and_sleep_tb
  import lcd_geom_pkg::*;
;
  // ****************************************
  // signals
  // ****************************************
  logic       clock = 1'b0;
  logic       reset = 1'b1;
  logic       write_strobe;
  logic       is_command;
  logic [7:0] write_data;
  logic       bus_drive_request;
  logic       font_8px = 1'b1;
  logic [2:0] mem_ctrl_in = 3'h5;
  geometry_t  geometry;
  geometry_t  g;
  scan_t      scan;
  logic [7:0] first_parameter_byte;
  logic [3:0] cell_pixels_wide;
  logic [4:0] cell_pixels_high;
  logic       cell_gap_column, cell_two_bytes, ac_waveform, column_blank;
  logic       row_driver_disable, display_enabled, tv_sync_run, clocks_halted;
  logic       data_bus_oe;
  logic [7:0] second_byte_mask;
  logic [8:0] bytes_per_line;
  logic [2:0] mem_ctrl_out;
  int         miscompares = 0;
  int         checks = 0;
  int         cycles = 0;
  int         n;

  always #10 clock = ~clock;

  lcd_host_model u_lcd_host_model (
    .clock(clock), .write_strobe(write_strobe), .is_command(is_command),
    .write_data(write_data), .bus_drive_request(bus_drive_request));

  lcd_frame_geometry_and_sleep u_lcd_frame_geometry_and_sleep (
    .clock(clock), .reset(reset), .write_strobe(write_strobe), .is_command(is_command),
    .write_data(write_data), .bus_drive_request(bus_drive_request), .font_8px(font_8px),
    .mem_ctrl_in(mem_ctrl_in), .geometry(geometry), .scan(scan),
    .first_parameter_byte(first_parameter_byte), .cell_pixels_wide(cell_pixels_wide),
    .cell_pixels_high(cell_pixels_high), .cell_gap_column(cell_gap_column),
    .cell_two_bytes(cell_two_bytes), .second_byte_mask(second_byte_mask),
    .bytes_per_line(bytes_per_line), .ac_waveform(ac_waveform),
    .column_blank(column_blank), .row_driver_disable(row_driver_disable),
    .display_enabled(display_enabled), .tv_sync_run(tv_sync_run),
    .clocks_halted(clocks_halted), .mem_ctrl_out(mem_ctrl_out), .data_bus_oe(data_bus_oe));

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic settle();
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask

  // full init stream, expected fields follow the byte layout
  task automatic load(input logic [7:0] p1, p2, p3, p4, p5, p6, p7, p8);
    u_lcd_host_model.xfer('{cmd_init, p1, p2, p3, p4, p5, p6, p7, p8}, 1'b1);
    g = '{p1[pos_split], p1[pos_tv], p2[pos_ac_sel], p2[3:0], p3[3:0], p4, p5, p6,
          {p8, p7}};
    settle();
  endtask

  function automatic logic pick(input int sel);
    return (sel == 0) ? scan.line_end : (sel == 1) ? scan.frame_end : ac_waveform;
  endfunction

  // cycles between two events: pulse for sel 0/1, toggle for sel 2
  task automatic period(input int sel, output int len);
    logic prev, cur;
    bit started;
    int k;
    prev = pick(sel);
    started = 0;
    k = 0;
    len = -1;
    for (int i = 0; i < 2000 && len < 0; i++) begin
      // sample between edges so the launching edge never races the read
      @(negedge clock);
      cur = pick(sel);
      if ((sel == 2) ? (cur !== prev) : (cur === 1'b1)) begin
        if (started) len = k;
        started = 1;
        k = 0;
      end
      k++;
      prev = cur;
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    @(negedge clock);
    g = '{1'b0, 1'b0, rst_ac_select, rst_cell_width, rst_cell_height, rst_line_span,
          rst_line_length, rst_frame_height, rst_pitch};
    check(geometry, g);
    check(first_parameter_byte, rst_first_param);
    check({column_blank, row_driver_disable}, 2'b10);
    $display("test reset done");
  endtask

  task automatic t_fields();
    // tv mode and dual drive, odd frame field, width eight
    load(8'h78, 8'h87, 8'h0f, 8'hef, 8'hf3, 8'h03, 8'h34, 8'h12);
    check(geometry, g);
    check(first_parameter_byte, 8'h78);
    check({tv_sync_run, cell_pixels_wide}, {1'b1, 4'h8});
    check({cell_pixels_high, bytes_per_line}, {5'd16, 9'd240});
    check(cell_two_bytes, 1'b0);
    load(8'h30, 8'h85, 8'h00, 8'h03, 8'h07, 8'h03, 8'h50, 8'h00);
    check(cell_pixels_wide, 4'h6);
    check({cell_pixels_high, bytes_per_line}, {5'd1, 9'd4});
    u_lcd_host_model.xfer('{cmd_init, 8'h30, 8'h8a}, 1'b1);
    settle();
    check(cell_gap_column, 1'b1);
    @(posedge clock);
    font_8px <= 1'b0;
    settle();
    check({cell_gap_column, cell_two_bytes}, 2'b01);
    check(second_byte_mask, 8'he0);
    @(posedge clock);
    font_8px <= 1'b1;
    $display("test fields done");
  endtask

  task automatic t_partial();
    load(8'h30, 8'h85, 8'h00, 8'h03, 8'h07, 8'h03, 8'h50, 8'h00);
    // pitch low only, then a new command ends the stream
    u_lcd_host_model.xfer('{cmd_init, 8'h30, 8'h85, 8'h00, 8'h03, 8'h07, 8'h03, 8'h66},
                          1'b1);
    u_lcd_host_model.xfer('{display_on_command}, 1'b1);
    u_lcd_host_model.xfer('{8'h99}, 1'b0);
    settle();
    g.virtual_screen_pitch = 16'h0066;
    check(geometry, g);
    check(display_enabled, 1'b1);
    $display("test partial done");
  endtask

  task automatic t_timing();
    period(0, n);
    check(n, 8);
    period(1, n);
    check(n, 32);
    period(2, n);
    check(n, 32);
    u_lcd_host_model.xfer('{cmd_init, 8'h30, 8'h05}, 1'b1);
    // second byte now selects 16-line drive, width field stays 5
    g.ac_drive_select = 1'b0;
    u_lcd_host_model.xfer('{display_on_command}, 1'b1);
    period(2, n);
    check(n, 128);
    $display("test timing done");
  endtask

  task automatic t_standby();
    u_lcd_host_model.set_read(1'b1);
    settle();
    check({data_bus_oe, mem_ctrl_out}, {1'b1, mem_ctrl_in});
    u_lcd_host_model.xfer('{cmd_standby}, 1'b1);
    n = 0;
    while (row_driver_disable !== 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    check(n >= 30 && n <= 70, 1'b1);
    settle();
    check({column_blank, clocks_halted, data_bus_oe}, 3'b110);
    n = scan.h_count;
    @(posedge clock);
    mem_ctrl_in <= 3'h2;
    u_lcd_host_model.xfer('{8'h11}, 1'b0);
    settle();
    check({scan.h_count, mem_ctrl_out}, {n[7:0], 3'h5});
    check(geometry, g);
    // leave with init plus its first byte only
    u_lcd_host_model.xfer('{cmd_init, 8'h30}, 1'b1);
    @(negedge clock);
    check({row_driver_disable, display_enabled}, 2'b00);
    u_lcd_host_model.xfer('{display_on_command}, 1'b1);
    settle();
    check({clocks_halted, display_enabled, data_bus_oe}, 3'b011);
    check(geometry, g);
    check(mem_ctrl_out, 3'h2);
    $display("test standby done");
  endtask

  // ****************************************
  // closing
  // ****************************************
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  initial begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    t_reset();
    t_fields();
    t_partial();
    t_timing();
    t_standby();
    stop_test();
  end
endmodule

//--- tb/lcd_host_model.sv
// host processor model driving the command/parameter byte port
`timescale 1ns/1ns
module lcd_host_model (
  // clock
  input  wire logic       clock,
  // byte port
  output logic            write_strobe,
  output logic            is_command,
  output logic      [7:0] write_data,
  output logic            bus_drive_request
);
  // ****************************************
  // idle levels
  // ****************************************
  initial begin
    write_strobe      = 1'b0;
    is_command        = 1'b0;
    write_data        = 8'h00;
    bus_drive_request = 1'b0;
  end

  // ****************************************
  // byte stream, back to back
  // ****************************************
  // first byte is a command when with_cmd is set
  // callers keep span+4 <= length, span <= 239, height 0 in graphics,
  // width <= 8 in tv mode, odd frame field in dual drive
  task automatic xfer(input logic [7:0] seq[$], input bit with_cmd);
    for (int i = 0; i < seq.size(); i++) begin
      @(posedge clock);
      write_strobe <= 1'b1;
      is_command   <= with_cmd && (i == 0);
      write_data   <= seq[i];
    end
    @(posedge clock);
    write_strobe <= 1'b0;
    // released bus shows no stale byte
    is_command   <= ~is_command;
    write_data   <= ~seq[seq.size()-1];
  endtask

  task automatic set_read(input logic level);
    @(posedge clock);
    bus_drive_request <= level;
  endtask
endmodule

//--- verilog/lcd_frame_geometry_and_sleep.sv
// module: display geometry registers, scan timing, AC waveform and standby control
`timescale 1ns/1ns
module lcd_frame_geometry_and_sleep
  import lcd_geom_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // host byte port
  input  wire logic       write_strobe,
  input  wire logic       is_command,
  input  wire logic [7:0] write_data,
  input  wire logic       bus_drive_request,
  // font option
  input  wire logic       font_8px,
  // display memory control levels from the memory side
  input  wire logic [2:0] mem_ctrl_in,
  // geometry and timing
  output geometry_t       geometry,
  output scan_t           scan,
  output logic [7:0]      first_parameter_byte,
  output logic [3:0]      cell_pixels_wide,
  output logic [4:0]      cell_pixels_high,
  output logic            cell_gap_column,
  output logic            cell_two_bytes,
  output logic [7:0]      second_byte_mask,
  output logic [8:0]      bytes_per_line,
  // panel drive
  output logic            ac_waveform,
  output logic            column_blank,
  output logic            row_driver_disable,
  output logic            display_enabled,
  output logic            tv_sync_run,
  output logic            clocks_halted,
  output logic [2:0]      mem_ctrl_out,
  output logic            data_bus_oe
);

  // ****************************************
  // byte decode
  // ****************************************
  logic [3:0]   param_index;
  logic         init_open;
  power_state_t state;
  power_state_t next_state;
  logic [1:0]   drain_frames;
  logic         ac_line_toggle;
  logic [3:0]   ac_line_count;
  logic         frame_pulse;
  logic         line_pulse;

  wire cmd_taken    = write_strobe && is_command;
  wire param_taken  = write_strobe && !is_command && init_open;
  wire take_init    = cmd_taken && (write_data == cmd_init);
  wire take_standby = cmd_taken && (write_data == cmd_standby) && (state == st_run);
  wire take_display_on_command = cmd_taken && (write_data == display_on_command);
  wire take_disp_off = cmd_taken && (write_data == cmd_display_off);
  wire asleep       = (state == st_sleep);
  wire timing_run   = (state != st_sleep);

  wire [7:0] p_first = write_data;

  // ****************************************
  // parameter index
  // ****************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      param_index <= 4'h0;
      init_open   <= 1'b0;
    end else if (cmd_taken) begin
      param_index <= 4'h0;
      init_open   <= take_init;
    end else if (param_taken) begin
      param_index <= param_index + 4'h1;
      init_open   <= (param_index < 4'(param_count - 1));
    end
  end

  // ****************************************
  // geometry registers
  // ****************************************
  // each byte is committed as it lands, the pitch halves included
  always_ff @(posedge clock) begin
    if (reset) begin
      first_parameter_byte              <= rst_first_param;
      geometry.split_panel              <= rst_first_param[pos_split];
      geometry.tv_mode                  <= rst_first_param[pos_tv];
      geometry.ac_drive_select          <= rst_ac_select;
      geometry.cell_width_field         <= rst_cell_width;
      geometry.cell_height_field        <= rst_cell_height;
      geometry.line_span_field          <= rst_line_span;
      geometry.total_line_length_field  <= rst_line_length;
      geometry.frame_height_field       <= rst_frame_height;
      geometry.virtual_screen_pitch     <= rst_pitch;
    end else if (param_taken) begin
      unique case (param_index)
        4'h0: begin
          first_parameter_byte <= p_first;
          geometry.split_panel <= p_first[pos_split];
          geometry.tv_mode     <= p_first[pos_tv];
        end
        4'h1: begin
          geometry.ac_drive_select  <= write_data[pos_ac_sel];
          geometry.cell_width_field <= write_data[3:0];
        end
        4'h2: geometry.cell_height_field       <= write_data[3:0];
        4'h3: geometry.line_span_field         <= write_data;
        4'h4: geometry.total_line_length_field <= write_data;
        4'h5: geometry.frame_height_field      <= write_data;
        4'h6: geometry.virtual_screen_pitch[7:0]  <= write_data;
        4'h7: geometry.virtual_screen_pitch[15:8] <= write_data;
        default: ;
      endcase
    end
  end

  // ****************************************
  // derived cell geometry
  // ****************************************
  wire [3:0] next_wide     = {1'b0, geometry.cell_width_field[2:0]} + 4'h1;
  wire [4:0] next_high     = {1'b0, geometry.cell_height_field} + 5'h01;
  wire       next_gap      = geometry.cell_width_field[3] && font_8px;
  wire       next_two      = geometry.cell_width_field[3] && !font_8px;
  // a 9..16 wide cell shows the leading width-8 bits of its second byte, all eight at width 16
  wire [2:0] rem_bits      = geometry.cell_width_field[2:0];
  wire [7:0] next_mask     = next_two ? ~(8'hff >> ({5'h00, rem_bits} + 8'h01))
                                      : 8'h00;
  wire [8:0] next_bytes    = {1'b0, geometry.line_span_field} + 9'h001;

  always_ff @(posedge clock) begin
    if (reset) begin
      cell_pixels_wide <= 4'h0;
      cell_pixels_high <= 5'h00;
      cell_gap_column  <= 1'b0;
      cell_two_bytes   <= 1'b0;
      second_byte_mask <= 8'h00;
      bytes_per_line   <= 9'h000;
    end else begin
      cell_pixels_wide <= next_wide;
      cell_pixels_high <= next_high;
      cell_gap_column  <= next_gap;
      cell_two_bytes   <= next_two;
      second_byte_mask <= next_mask;
      bytes_per_line   <= next_bytes;
    end
  end

  // ****************************************
  // scan timing
  // ****************************************
  logic [7:0] h_count;
  logic [7:0] v_count;
  logic       h_wrap;
  logic       v_wrap;

  // byte-period counter; halted clocks in sleep are modelled by holding it
  scan_counter u_hcount (
    .clock (clock),
    .reset (reset),
    .clear (take_init),
    .step  (timing_run),
    .last  (geometry.total_line_length_field),
    .count (h_count),
    .wrap  (h_wrap)
  );

  scan_counter u_vcount (
    .clock (clock),
    .reset (reset),
    .clear (take_init),
    .step  (h_wrap),
    .last  (geometry.frame_height_field),
    .count (v_count),
    .wrap  (v_wrap)
  );

  assign line_pulse  = h_wrap && !take_init;
  assign frame_pulse = v_wrap && !take_init;

  // blank column data beyond the programmed span
  wire in_span = (h_count <= geometry.line_span_field);

  always_ff @(posedge clock) begin
    if (reset) begin
      scan <= '0;
    end else begin
      scan.h_count   <= h_count;
      scan.v_count   <= v_count;
      scan.line_end  <= line_pulse;
      scan.frame_end <= frame_pulse;
    end
  end

  // ****************************************
  // AC waveform
  // ****************************************
  wire ac_sixteen = line_pulse && (ac_line_count == ac_line_period);

  always_ff @(posedge clock) begin
    if (reset || take_init) begin
      ac_line_count <= 4'h0;
      ac_waveform   <= 1'b0;
    end else begin
      if (line_pulse) begin
        ac_line_count <= ac_line_count + 4'h1;
      end
      if (geometry.ac_drive_select ? frame_pulse : ac_sixteen) begin
        ac_waveform <= !ac_waveform;
      end
    end
  end

  assign ac_line_toggle = ac_sixteen;

  // ****************************************
  // standby sequencing
  // ****************************************
  // row disable rises at the second frame boundary after the command: the
  // first boundary may come right away, so waiting for two keeps at least
  // one full blank frame and never more than two
  always_comb begin
    next_state = state;
    unique case (state)
      st_run: begin
        if (take_standby) begin
          next_state = st_drain;
        end
      end
      st_drain: begin
        if (take_init) begin
          next_state = st_run;
        end else if (frame_pulse && drain_frames == sleep_frames_min) begin
          next_state = st_sleep;
        end
      end
      st_sleep: begin
        if (take_init) begin
          next_state = st_run;
        end
      end
      default: next_state = st_run;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state        <= st_run;
      drain_frames <= 2'h0;
    end else begin
      state <= next_state;
      if (state != st_drain) begin
        drain_frames <= 2'h0;
      end else if (frame_pulse) begin
        drain_frames <= drain_frames + 2'h1;
      end
    end
  end

  // ****************************************
  // display enable
  // ****************************************
  always_ff @(posedge clock) begin
    if (reset || take_init || take_standby) begin
      display_enabled <= 1'b0;
    end else if (take_display_on_command) begin
      display_enabled <= 1'b1;
    end else if (take_disp_off) begin
      display_enabled <= 1'b0;
    end
  end

  // ****************************************
  // panel and bus outputs
  // ****************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      column_blank       <= 1'b1;
      row_driver_disable <= 1'b0;
      tv_sync_run        <= 1'b0;
      clocks_halted      <= 1'b0;
      mem_ctrl_out       <= 3'h0;
      data_bus_oe        <= 1'b0;
    end else begin
      column_blank       <= (next_state != st_run) || !display_enabled || !in_span;
      row_driver_disable <= (next_state == st_sleep);
      tv_sync_run        <= geometry.tv_mode && (next_state != st_sleep);
      clocks_halted      <= (next_state == st_sleep);
      if (next_state != st_sleep) begin
        mem_ctrl_out <= mem_ctrl_in;
      end
      data_bus_oe <= bus_drive_request && (next_state != st_sleep);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_sleep_entry: assert property (@(posedge clock) disable iff (reset)
    take_standby |-> !row_driver_disable [*2])
    else $error("row disable asserted too soon after standby");

  chk_init_wakes: assert property (@(posedge clock) disable iff (reset)
    (asleep && take_init) |=> !clocks_halted && !display_enabled)
    else $error("init did not cancel sleep");

  chk_bus_released: assert property (@(posedge clock) disable iff (reset)
    row_driver_disable |-> !data_bus_oe)
    else $error("bus driven while asleep");

  chk_sleep_blank: assert property (@(posedge clock) disable iff (reset)
    row_driver_disable |-> column_blank)
    else $error("columns not blank in sleep");

  chk_mem_hold: assert property (@(posedge clock) disable iff (reset)
    (asleep && $past(asleep) && !take_init) |=> $stable(mem_ctrl_out))
    else $error("memory controls moved in sleep");

  chk_frame_ac: assert property (@(posedge clock) disable iff (reset)
    (geometry.ac_drive_select && frame_pulse && !take_init && $stable(geometry.ac_drive_select))
      |=> ac_waveform != $past(ac_waveform))
    else $error("ac waveform missed frame toggle");

  chk_line_ac: assert property (@(posedge clock) disable iff (reset)
    (!geometry.ac_drive_select && line_pulse && !ac_line_toggle && !frame_pulse)
      |=> $stable(ac_waveform))
    else $error("ac waveform toggled off the 16-line boundary");

  chk_standby_param: assert property (@(posedge clock) disable iff (reset)
    (cmd_taken && write_data == cmd_standby) |=> !init_open)
    else $error("standby opened parameter stream");

  chk_line_len: assert property (@(posedge clock) disable iff (reset)
    (timing_run && !take_init) |-> h_count <= geometry.total_line_length_field
      || $changed(geometry.total_line_length_field) || $past(param_taken))
    else $error("byte counter ran past line length");

  chk_pitch_low: assert property (@(posedge clock) disable iff (reset)
    (param_taken && param_index == 4'h6) |=>
      geometry.virtual_screen_pitch[7:0] == $past(write_data))
    else $error("pitch low byte not committed alone");

endmodule

//--- verilog/lcd_geom_pkg.sv
// package: command codes, parameter layout, reset values and carriers for the geometry block
package lcd_geom_pkg;

  // ****************************************
  // command bytes
  // ****************************************
  localparam logic [7:0] cmd_init           = 8'h40;
  localparam logic [7:0] cmd_standby        = 8'h53;
  localparam logic [7:0] display_on_command = 8'h59;
  localparam logic [7:0] cmd_display_off    = 8'h58;

  // ****************************************
  // first parameter byte bit positions
  // ****************************************
  localparam int pos_split  = 3;
  localparam int pos_tv     = 6;
  // second parameter byte
  localparam int pos_ac_sel = 7;
  localparam int pos_gap    = 3;

  // ****************************************
  // field widths and reset values
  // ****************************************
  localparam int          param_count      = 8;
  localparam logic [7:0]  rst_first_param  = 8'h30;
  localparam logic [3:0]  rst_cell_width   = 4'h7;
  localparam logic [3:0]  rst_cell_height  = 4'h7;
  localparam logic [7:0]  rst_line_span    = 8'h27;
  localparam logic [7:0]  rst_line_length  = 8'h2f;
  localparam logic [7:0]  rst_frame_height = 8'hef;
  localparam logic [15:0] rst_pitch        = 16'h0028;
  localparam logic        rst_ac_select    = 1'b1;
  localparam logic [3:0]  ac_line_period   = 4'hf;
  localparam logic [7:0]  byte_width       = 8'h08;
  localparam logic [1:0]  sleep_frames_min = 2'h1;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic        split_panel;
    logic        tv_mode;
    logic        ac_drive_select;
    logic [3:0]  cell_width_field;
    logic [3:0]  cell_height_field;
    logic [7:0]  line_span_field;
    logic [7:0]  total_line_length_field;
    logic [7:0]  frame_height_field;
    logic [15:0] virtual_screen_pitch;
  } geometry_t;

  typedef struct packed {
    logic [7:0] h_count;
    logic [7:0] v_count;
    logic       line_end;
    logic       frame_end;
  } scan_t;

  typedef enum logic [1:0] {
    st_run   = 2'b00,
    st_drain = 2'b01,
    st_sleep = 2'b10
  } power_state_t;

endpackage

//--- verilog/scan_counter.sv
// module: wrap-around counter used for byte periods and scan lines
`timescale 1ns/1ns
module scan_counter (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // control
  input  wire logic       clear,
  input  wire logic       step,
  input  wire logic [7:0] last,
  // state
  output logic      [7:0] count,
  output logic            wrap
);

  assign wrap = step && (count >= last);

  always_ff @(posedge clock) begin
    if (reset || clear) begin
      count <= 8'h00;
    end else if (wrap) begin
      count <= 8'h00;
    end else if (step) begin
      count <= count + 8'h01;
    end
  end

endmodule
